// File: hdl/ccr_pkg.sv
package ccr_pkg;

	// ********************************************************
	// Bus geometry and register indices (byte address = 4 * index)
	// ********************************************************
	localparam int         ADDR_W       = 12;
	localparam int         IDX_W        = 10;
	localparam logic [9:0] IDX_PARK     = 10'h064;
	localparam logic [9:0] IDX_AVG      = 10'h068;
	localparam logic [9:0] IDX_STATUS   = 10'h06A;
	localparam logic [9:0] IDX_PIN      = 10'h06B;
	localparam logic [9:0] IDX_SOFT     = 10'h06C;
	localparam logic [9:0] IDX_CTRL     = 10'h070;
	localparam logic [9:0] IDX_IRQ_STS  = 10'h071;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h072;

	// ********************************************************
	// Values after reset
	// ********************************************************
	localparam logic [7:0] RST_PARK   = 8'h01;
	localparam logic [7:0] RST_AVG    = 8'h61;
	localparam logic [7:0] RST_STATUS = 8'h00;
	localparam logic [7:0] RST_PIN    = 8'h00;
	localparam logic [7:0] RST_SOFT   = 8'h01;
	localparam logic [7:0] RST_CTRL   = 8'h01;
	localparam logic [7:0] RST_IRQ    = 8'h00;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int PARK_LSB     = 0;
	localparam int OSAVG_LSB    = 4;
	localparam int LINAVG_LSB   = 0;
	localparam int STS_FG       = 0;
	localparam int STS_HALT     = 1;
	localparam int STS_CODE_LSB = 2;
	localparam int PIN_TRIGSEL  = 0;
	localparam int PIN_SRC_LSB  = 1;
	localparam int SOFT_BIT     = 0;
	localparam int CTRL_FG      = 0;
	localparam int CTRL_BG      = 1;
	localparam int CTRL_LINK    = 2;
	localparam int IRQ_FG       = 0;
	localparam int IRQ_HALT     = 1;
	localparam int IRQ_ALARM    = 2;
	localparam int IRQ_TRIG     = 3;
	localparam int IRQ_N        = 4;
	localparam int CORE_N       = 3;

	// ********************************************************
	// Codes
	// ********************************************************
	localparam logic [1:0] PARK_RSVD = 2'h3;
	localparam logic [1:0] SRC_FG    = 2'h0;
	localparam logic [1:0] SRC_HALT  = 2'h1;
	localparam logic [1:0] SRC_ALARM = 2'h2;
	localparam logic [1:0] SRC_LOW   = 2'h3;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_FOREGROUND,
		PH_BACKGROUND,
		PH_HALTED,
		PH_PARKED
	} ccr_phase_e;

	// ********************************************************
	// Calibration engine carriers
	// ********************************************************
	typedef struct packed {
		logic       fgDone;     // Foreground run finished, pulse
		logic       bgStopped;  // Background stopped at phase, pulse
		logic       bgResumed;  // Background running again, pulse
		logic       alarm;      // Alarm level
		logic [2:0] statCode;   // Status code of the engine
	} ccr_engine_in_s;

	typedef struct packed {
		logic       restart;        // Reset calibration values, pulse
		logic       fgRun;          // Run foreground after restart
		logic       bgEnable;       // Continuous background run
		logic [2:0] offsetAvg;      // Offset averaging depth
		logic [2:0] linAvg;         // Linearity averaging depth
		logic [2:0] coreDisable;    // One bit per converter core
		logic       core1ForCore0;  // Core one substitutes core zero
		logic       core1ForCore2;  // Core one substitutes core two
		logic       trigger;        // Selected calibration trigger
	} ccr_engine_out_s;

endpackage : ccr_pkg

// File: hdl/ccr_sync.sv
`timescale 1ns/10ps
module ccr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,  // Device clock
	input  wire logic             reset,    // Synchronous reset
	input  wire logic [WIDTH-1:0] asyncIn,  // Foreign-domain level
	output logic      [WIDTH-1:0] syncOut   // Synchronised level
);

	logic [WIDTH-1:0] stageOneReg;

	initial begin
		if (WIDTH < 1) begin
			$error("ccr_sync: WIDTH must be at least one");
		end
	end

	// Two flip-flops; the first is read by the second only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stageOneReg <= '0;
			syncOut     <= '0;
		end else begin
			stageOneReg <= asyncIn;
			syncOut     <= stageOneReg;
		end
	end

endmodule : ccr_sync

// File: hdl/ccr_regs.sv
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
module ccr_regs (
	input  wire logic                        sys_clk,  // Device clock
	input  wire logic                        reset,    // Sync, active high
	input  wire logic                        psel,     // APB select
	input  wire logic                        penable,  // APB enable
	input  wire logic                        pwrite,   // APB direction
	input  wire logic [ccr_pkg::ADDR_W-1:0]  paddr,    // APB byte address
	input  wire logic [31:0]                 pwdata,   // APB write data
	output logic      [31:0]                 prdata,   // APB read data
	output logic                             pready,   // APB ready
	output logic                             pslverr,  // APB error
	input  wire logic                        hardwareTriggerPin, // Pin
	input  wire ccr_pkg::ccr_engine_in_s     engIn,    // From engine
	output ccr_pkg::ccr_engine_out_s         engOut,   // To engine
	output logic                             calibrationStatePin, // Pin
	output logic                             serialLinkEnable, // Link on
	output logic                             irq       // Level interrupt
);

	// ********************************************************
	// Declarations
	// ********************************************************
	localparam int IRQ_N = ccr_pkg::IRQ_N;

	logic [7:0]                   parkReg;
	logic [7:0]                   avgReg;
	logic [7:0]                   pinReg;
	logic [7:0]                   softReg;
	logic [7:0]                   ctrlReg;
	logic [IRQ_N-1:0]             irqStsReg;
	logic [IRQ_N-1:0]             irqMaskReg;
	logic                         fgFlagReg;
	logic                         fgFlagNext;
	logic                         haltFlagReg;
	logic                         haltFlagNext;
	logic [2:0]                   codeReg;
	ccr_pkg::ccr_phase_e          phaseReg;
	ccr_pkg::ccr_phase_e          phaseNext;
	logic                         startPendReg;
	logic                         trigPrevReg;
	logic                         alarmPrevReg;
	logic                         hwTrigSync;
	logic                         trigSel;
	logic                         restart;
	logic                         fgFinish;
	logic [ccr_pkg::IDX_W-1:0]    idx;
	logic                         mapped;
	logic                         wrStrobe;
	logic [7:0]                   wByte;
	logic [7:0]                   rdByte;
	logic [7:0]                   statusByte;
	logic [IRQ_N-1:0]             irqEvents;
	logic [ccr_pkg::CORE_N-1:0]   coreOff;
	logic [1:0]                   parkCode;
	logic [1:0]                   pinSrc;
	logic                         bgOn;
	logic                         bgNext;

	// ********************************************************
	// Bus decode
	// ********************************************************

	// Word index and write strobe at the access edge
	assign idx      = paddr[ccr_pkg::ADDR_W-1:2];
	assign wrStrobe = psel && penable && pwrite && mapped;
	assign wByte    = pwdata[7:0];
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;

	// Known indices; everything else answers with an error
	always_comb begin
		case (idx)
			ccr_pkg::IDX_PARK,
			ccr_pkg::IDX_AVG,
			ccr_pkg::IDX_STATUS,
			ccr_pkg::IDX_PIN,
			ccr_pkg::IDX_SOFT,
			ccr_pkg::IDX_CTRL,
			ccr_pkg::IDX_IRQ_STS,
			ccr_pkg::IDX_IRQ_MASK: mapped = 1'b1;
			default:               mapped = 1'b0;
		endcase
	end

	// ********************************************************
	// Writable registers, full bytes kept except the interrupt mask (low four bits)
	// ********************************************************

	// Reserved bits are stored and read back untouched, except in the interrupt mask
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			parkReg    <= ccr_pkg::RST_PARK;
			avgReg     <= ccr_pkg::RST_AVG;
			pinReg     <= ccr_pkg::RST_PIN;
			softReg    <= ccr_pkg::RST_SOFT;
			ctrlReg    <= ccr_pkg::RST_CTRL;
			irqMaskReg <= '0;
		end else if (wrStrobe) begin
			case (idx)
				ccr_pkg::IDX_PARK:     parkReg    <= wByte;
				ccr_pkg::IDX_AVG:      avgReg     <= wByte;
				ccr_pkg::IDX_PIN:      pinReg     <= wByte;
				ccr_pkg::IDX_SOFT:     softReg    <= wByte;
				ccr_pkg::IDX_CTRL:     ctrlReg    <= wByte;
				ccr_pkg::IDX_IRQ_MASK: irqMaskReg <= wByte[IRQ_N-1:0];
				default:               ;  // Status is read-only
			endcase
		end
	end

	// ********************************************************
	// Field extraction
	// ********************************************************
	assign parkCode = parkReg[ccr_pkg::PARK_LSB +: 2];
	assign pinSrc   = pinReg[ccr_pkg::PIN_SRC_LSB +: 2];
	assign trigSel  = pinReg[ccr_pkg::PIN_TRIGSEL];
	assign bgOn     = ctrlReg[ccr_pkg::CTRL_BG];

	// Background enable as it stands after a control write on this edge
	assign bgNext = (wrStrobe && idx == ccr_pkg::IDX_CTRL) ?
		wByte[ccr_pkg::CTRL_BG] : bgOn;
	assign serialLinkEnable = ctrlReg[ccr_pkg::CTRL_LINK];

	// ********************************************************
	// Hardware trigger pin crossing
	// ********************************************************
	ccr_sync #(
		.WIDTH (1)
	) u_trigSync (
		.sys_clk (sys_clk),
		.reset   (reset),
		.asyncIn (hardwareTriggerPin),
		.syncOut (hwTrigSync)
	);

	// ********************************************************
	// Calibration phase tracking
	// ********************************************************

	// Restart on reset release and on every control write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			startPendReg <= 1'b1;
		end else begin
			startPendReg <= 1'b0;
		end
	end

	assign restart = startPendReg ||
		(wrStrobe && idx == ccr_pkg::IDX_CTRL);

	// Phase sequencing from engine events and control bits
	always_comb begin
		phaseNext = phaseReg;
		fgFinish  = 1'b0;
		if (restart) begin
			// A control write brings its own foreground bit
			if (startPendReg ? ctrlReg[ccr_pkg::CTRL_FG]
				: wByte[ccr_pkg::CTRL_FG]) begin
				phaseNext = ccr_pkg::PH_FOREGROUND;
			end else begin
				fgFinish  = 1'b1;                     // Skipped
			end
		end else begin
			case (phaseReg)
				ccr_pkg::PH_IDLE: begin
					phaseNext = ccr_pkg::PH_IDLE;
				end
				ccr_pkg::PH_FOREGROUND: begin
					if (engIn.fgDone) begin
						fgFinish = 1'b1;
					end
				end
				ccr_pkg::PH_BACKGROUND: begin
					if (!bgOn) begin
						phaseNext = ccr_pkg::PH_PARKED;
					end else if (engIn.bgStopped) begin
						phaseNext = ccr_pkg::PH_HALTED;
					end
				end
				ccr_pkg::PH_HALTED: begin
					if (!bgOn) begin
						phaseNext = ccr_pkg::PH_PARKED;
					end else if (engIn.bgResumed) begin
						phaseNext = ccr_pkg::PH_BACKGROUND;
					end
				end
				ccr_pkg::PH_PARKED: begin
					if (bgOn) begin
						phaseNext = ccr_pkg::PH_BACKGROUND;
					end
				end
				default: phaseNext = ccr_pkg::PH_IDLE;
			endcase
		end
		if (fgFinish) begin
			phaseNext = bgNext ? ccr_pkg::PH_BACKGROUND
				: ccr_pkg::PH_PARKED;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phaseReg <= ccr_pkg::PH_IDLE;
		end else begin
			phaseReg <= phaseNext;
		end
	end

	// ********************************************************
	// Status flags
	// ********************************************************

	// Completion flag: cleared by restart, set by finish or skip
	assign fgFlagNext = fgFinish ? 1'b1
		: (restart ? 1'b0 : fgFlagReg);

	// Halted while stopped, or parked after foreground end
	assign haltFlagNext = phaseNext == ccr_pkg::PH_HALTED ||
		phaseNext == ccr_pkg::PH_PARKED;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fgFlagReg   <= ccr_pkg::RST_STATUS[ccr_pkg::STS_FG];
			haltFlagReg <= ccr_pkg::RST_STATUS[ccr_pkg::STS_HALT];
			codeReg     <= ccr_pkg::RST_STATUS[ccr_pkg::STS_CODE_LSB +: 3];
		end else begin
			fgFlagReg   <= fgFlagNext;
			haltFlagReg <= haltFlagNext;
			codeReg     <= engIn.statCode;
		end
	end

	// Read-only view of the flags
	always_comb begin
		statusByte = 8'h00;
		statusByte[ccr_pkg::STS_FG]   = fgFlagReg;
		statusByte[ccr_pkg::STS_HALT] = haltFlagReg;
		statusByte[ccr_pkg::STS_CODE_LSB +: 3] = codeReg;
	end

	// ********************************************************
	// Interrupt status and mask
	// ********************************************************

	// Rising edges of flags, alarm and selected trigger
	always_comb begin
		irqEvents = '0;
		irqEvents[ccr_pkg::IRQ_FG]    = fgFlagNext && !fgFlagReg;
		irqEvents[ccr_pkg::IRQ_HALT]  = haltFlagNext && !haltFlagReg;
		irqEvents[ccr_pkg::IRQ_ALARM] = engIn.alarm && !alarmPrevReg;
		irqEvents[ccr_pkg::IRQ_TRIG]  = engOut.trigger && !trigPrevReg;
	end

	// Write one clears; a new event in the same cycle wins
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irqStsReg    <= ccr_pkg::RST_IRQ[IRQ_N-1:0];
			alarmPrevReg <= 1'b0;
			trigPrevReg  <= 1'b0;
		end else begin
			alarmPrevReg <= engIn.alarm;
			trigPrevReg  <= engOut.trigger;
			if (wrStrobe && idx == ccr_pkg::IDX_IRQ_STS) begin
				irqStsReg <= (irqStsReg & ~wByte[IRQ_N-1:0]) | irqEvents;
			end else begin
				irqStsReg <= irqStsReg | irqEvents;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |((irqStsReg | irqEvents) & irqMaskReg);
		end
	end

	// ********************************************************
	// Engine controls
	// ********************************************************

	// Core disable per core, only while background is off
	generate
		for (genvar c = 0; c < ccr_pkg::CORE_N; c++) begin : g_core
			assign coreOff[c] = !bgOn && parkCode != ccr_pkg::PARK_RSVD &&
				parkCode == 2'(c);
		end
	endgenerate

	// Registered engine interface
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			engOut <= '0;
		end else begin
			engOut.restart       <= restart;
			engOut.fgRun         <= ctrlReg[ccr_pkg::CTRL_FG];
			engOut.bgEnable      <= bgOn;
			engOut.offsetAvg     <= avgReg[ccr_pkg::OSAVG_LSB +: 3];
			engOut.linAvg        <= avgReg[ccr_pkg::LINAVG_LSB +: 3];
			engOut.coreDisable   <= coreOff;
			engOut.core1ForCore0 <= coreOff[0];
			engOut.core1ForCore2 <= coreOff[2];
			engOut.trigger       <= trigSel ? hwTrigSync
				: softReg[ccr_pkg::SOFT_BIT];
		end
	end

	// ********************************************************
	// Status output pin
	// ********************************************************

	// Source selection for the status pin
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			calibrationStatePin <= 1'b0;
		end else begin
			case (pinSrc)
				ccr_pkg::SRC_FG:    calibrationStatePin <= fgFlagReg;
				ccr_pkg::SRC_HALT:  calibrationStatePin <= haltFlagReg;
				ccr_pkg::SRC_ALARM: calibrationStatePin <= engIn.alarm;
				ccr_pkg::SRC_LOW:   calibrationStatePin <= 1'b0;
				default:            calibrationStatePin <= 1'b0;
			endcase
		end
	end

	// ********************************************************
	// Read path
	// ********************************************************

	// Read byte for the addressed register
	always_comb begin
		case (idx)
			ccr_pkg::IDX_PARK:     rdByte = parkReg;
			ccr_pkg::IDX_AVG:      rdByte = avgReg;
			ccr_pkg::IDX_STATUS:   rdByte = statusByte;
			ccr_pkg::IDX_PIN:      rdByte = pinReg;
			ccr_pkg::IDX_SOFT:     rdByte = softReg;
			ccr_pkg::IDX_CTRL:     rdByte = ctrlReg;
			ccr_pkg::IDX_IRQ_STS:  rdByte = 8'(irqStsReg);
			ccr_pkg::IDX_IRQ_MASK: rdByte = 8'(irqMaskReg);
			default:               rdByte = 8'h00;
		endcase
	end

	// Data captured in the setup cycle, valid in the access cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= {24'h000000, rdByte};
		end
	end

endmodule : ccr_regs

// File: testbench/ccr_checker.sv
`timescale 1ns/10ps
module ccr_checker (
	input wire logic                     sys_clk,             // Clock
	input wire logic                     reset,               // Reset
	input wire logic                     psel,                // Select
	input wire logic                     penable,             // Enable
	input wire logic                     pwrite,              // Write
	input wire logic [ccr_pkg::ADDR_W-1:0] paddr,             // Address
	input wire logic [31:0]              pwdata,              // Data in
	input wire logic [31:0]              prdata,              // Data out
	input wire logic                     pready,              // Ready
	input wire logic                     pslverr,             // Error
	input wire logic                     hardwareTriggerPin,  // Pin
	input wire ccr_pkg::ccr_engine_in_s  engIn,               // Engine in
	input wire ccr_pkg::ccr_engine_out_s engOut,              // Engine out
	input wire logic                     calibrationStatePin, // Pin
	input wire logic                     serialLinkEnable,    // Link
	input wire logic                     irq                  // Interrupt
);
	// ****
	// Shadows
	// ****
	logic [7:0] parkSh, avgSh, pinSh, softSh;
	logic       bgSh;
	logic [2:0] quiet;
	logic [2:0] expDis;
	logic       wrEn;
	logic [9:0] idx;
	logic [1:0] src;

	// Decode of the transfer and expected core disables
	assign wrEn   = psel && penable && pwrite;
	assign idx    = paddr[11:2];
	assign src    = pinSh[2:1];
	assign expDis = (bgSh || parkSh[1:0] == 2'h3) ? 3'h0 : 3'h1 << parkSh[1:0];

	// Written values; quiet counts cycles since the last write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			parkSh <= ccr_pkg::RST_PARK;
			avgSh  <= ccr_pkg::RST_AVG;
			pinSh  <= ccr_pkg::RST_PIN;
			softSh <= ccr_pkg::RST_SOFT;
			bgSh   <= 1'h0;
			quiet  <= 3'h0;
		end else begin
			if (wrEn && idx == ccr_pkg::IDX_PARK) parkSh <= pwdata[7:0];
			if (wrEn && idx == ccr_pkg::IDX_AVG) avgSh <= pwdata[7:0];
			if (wrEn && idx == ccr_pkg::IDX_PIN) pinSh <= pwdata[7:0];
			if (wrEn && idx == ccr_pkg::IDX_SOFT) softSh <= pwdata[7:0];
			if (wrEn && idx == ccr_pkg::IDX_CTRL) bgSh <= pwdata[1];
			quiet <= wrEn ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
		end
	end

	// ****
	// Properties
	// ****
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	property p_park;
		quiet > 3'h1 |-> engOut.coreDisable == expDis
			&& engOut.core1ForCore0 == (expDis == 3'h1)
			&& engOut.core1ForCore2 == (expDis == 3'h4);
	endproperty
	a_park: assert property (p_park) else $error("park");

	property p_avg;
		quiet > 3'h1 |-> engOut.offsetAvg == avgSh[6:4]
			&& engOut.linAvg == avgSh[2:0];
	endproperty
	a_avg: assert property (p_avg) else $error("depth");

	property p_soft;
		quiet > 3'h1 && !pinSh[0] |-> engOut.trigger == softSh[0];
	endproperty
	a_soft: assert property (p_soft) else $error("soft");

	property p_hw;
		quiet > 3'h4 && pinSh[0]
			|-> engOut.trigger == $past(hardwareTriggerPin, 3);
	endproperty
	a_hw: assert property (p_hw) else $error("pin trigger");

	property p_low;
		quiet > 3'h1 && src == ccr_pkg::SRC_LOW |-> !calibrationStatePin;
	endproperty
	a_low: assert property (p_low) else $error("pin low");

	property p_fg;
		engIn.fgDone && src == ccr_pkg::SRC_FG
			|-> ##[1:3] calibrationStatePin;
	endproperty
	a_fg: assert property (p_fg) else $error("fg flag");

	property p_halt;
		engIn.bgStopped && src == ccr_pkg::SRC_HALT
			|-> ##[1:3] calibrationStatePin;
	endproperty
	a_halt: assert property (p_halt) else $error("halt");

	property p_restart;
		wrEn && idx == ccr_pkg::IDX_CTRL |-> ##[1:3] engOut.restart;
	endproperty
	a_restart: assert property (p_restart) else $error("restart");

	property p_irq;
		wrEn && idx == ccr_pkg::IDX_IRQ_MASK && pwdata[3:0] == 4'h0
			|-> ##2 !irq;
	endproperty
	a_irq: assert property (p_irq) else $error("irq mask");

	// Main scenarios
	c_stop: cover property (engIn.bgStopped);
	c_fg: cover property (engIn.fgDone && !engOut.bgEnable);
	c_irq: cover property (irq);
endmodule : ccr_checker

bind ccr_regs ccr_checker ccr_checker_inst (.sys_clk, .reset, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.hardwareTriggerPin, .engIn, .engOut, .calibrationStatePin,
	.serialLinkEnable, .irq);

// File: testbench/ccr_host_model.sv
`timescale 1ns/10ps
module ccr_host_model (
	input  wire logic               sys_clk,           // Clock
	output ccr_pkg::ccr_engine_in_s engIn,             // Engine events
	output logic                    hardwareTriggerPin // Trigger pin
);
	// Quiet engine, low pin
	initial begin
		engIn = '0;
		hardwareTriggerPin = 1'h0;
	end

	// One-cycle event: 0 done, 1 stopped, 2 resumed
	task automatic pulse(input int k);
		repeat (2) @(posedge sys_clk);
		engIn[6:4] <= 3'h4 >> k;
		@(posedge sys_clk);
		engIn[6:4] <= 3'h0;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask : pulse

	// Alarm level
	task automatic setAlarm(input logic v);
		@(posedge sys_clk);
		engIn.alarm <= v;
	endtask : setAlarm

	// Engine status code level
	task automatic setCode(input logic [2:0] v);
		@(posedge sys_clk);
		engIn.statCode <= v;
	endtask : setCode

	// Host drives the trigger level
	task automatic setPin(input logic v);
		@(posedge sys_clk);
		hardwareTriggerPin <= v;
	endtask : setPin
endmodule : ccr_host_model

// File: testbench/ccr_regs_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %0h got %0h", n, e, g); end end
module ccr_regs_bench;
	logic                     sys_clk = 1'h0;
	logic                     reset   = 1'h1;
	logic                     psel;
	logic                     penable;
	logic                     pwrite;
	logic [11:0]              paddr;
	logic [31:0]              pwdata;
	logic [31:0]              prdata, rd;
	logic                     pready, pslverr, err;
	logic                     hardwareTriggerPin, calibrationStatePin;
	logic                     serialLinkEnable, irq;
	ccr_pkg::ccr_engine_in_s  engIn;
	ccr_pkg::ccr_engine_out_s engOut;
	int                       checks = 0;
	int                       miscompares = 0;

	// 40 ns period
	always #20 sys_clk = ~sys_clk;

	ccr_regs ccr_regs_inst (.sys_clk, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .hardwareTriggerPin,
		.engIn, .engOut, .calibrationStatePin, .serialLinkEnable, .irq);
	ccr_host_model ccr_host_model_inst (.sys_clk, .engIn,
		.hardwareTriggerPin);

	// One transfer; data and error taken at the ready edge
	task automatic apb(input logic w, input logic [9:0] ix,
		input logic [7:0] d);
		int n = 0;
		@(posedge sys_clk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= {ix, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'h1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		`CHK("pready", 1'h1, pready)
		rd = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic wr(input logic [9:0] ix, input logic [7:0] d);
		apb(1'h1, ix, d);
	endtask : wr

	task automatic rdChk(input logic [9:0] ix, input logic [7:0] e);
		apb(1'h0, ix, 8'h00);
		`CHK("read", {24'h0, e}, rd)
	endtask : rdChk

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	// Verdict
	task automatic results;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	// Watchdog, far beyond the sequence length
	initial begin
		repeat (3000) @(posedge sys_clk);
		miscompares++;
		results();
	end

	// Test sequence
	initial begin
		psel    <= 1'h0;
		penable <= 1'h0;
		pwrite  <= 1'h0;
		paddr   <= 12'h000;
		pwdata  <= 32'h0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'h0;
		rdChk(ccr_pkg::IDX_PARK, 8'h01);
		rdChk(ccr_pkg::IDX_AVG, 8'h61);
		rdChk(ccr_pkg::IDX_PIN, 8'h00);
		rdChk(ccr_pkg::IDX_SOFT, 8'h01);
		rdChk(ccr_pkg::IDX_CTRL, 8'h01);
		rdChk(ccr_pkg::IDX_IRQ_MASK, 8'h00);
		wr(ccr_pkg::IDX_STATUS, 8'hFF);
		rdChk(ccr_pkg::IDX_STATUS, 8'h00);
		apb(1'h1, 10'h3FF, 8'h5A);
		`CHK("pslverr", 1'h1, err)
		apb(1'h0, 10'h3FF, 8'h00);
		`CHK("pslverr", 1'h1, err)
		`CHK("unmapped", 32'h0, rd)
		wr(ccr_pkg::IDX_AVG, 8'hA5);
		rdChk(ccr_pkg::IDX_AVG, 8'hA5);
		`CHK("offsetAvg", 3'h2, engOut.offsetAvg)
		`CHK("linAvg", 3'h5, engOut.linAvg)
		// Foreground end with background off
		wr(ccr_pkg::IDX_PIN, 8'h02);
		ccr_host_model_inst.pulse(0);
		`CHK("statePin", 1'h1, calibrationStatePin)
		rdChk(ccr_pkg::IDX_STATUS, 8'h03);
		for (int c = 3; c >= 0; c--) begin
			wr(ccr_pkg::IDX_PARK, {6'h2A, c[1:0]});
			tick(2);
			`CHK("coreDisable", c == 3 ? 3'h0 : 3'h1 << c,
				engOut.coreDisable)
			`CHK("sub0", c == 0, engOut.core1ForCore0)
			`CHK("sub2", c == 2, engOut.core1ForCore2)
			rdChk(ccr_pkg::IDX_PARK, {6'h2A, c[1:0]});
		end
		// Background run, stop and resume
		wr(ccr_pkg::IDX_PIN, 8'h00);
		wr(ccr_pkg::IDX_CTRL, 8'h03);
		ccr_host_model_inst.pulse(0);
		`CHK("bgEnable", 1'h1, engOut.bgEnable)
		`CHK("coreDisable", 3'h0, engOut.coreDisable)
		rdChk(ccr_pkg::IDX_STATUS, 8'h01);
		wr(ccr_pkg::IDX_PIN, 8'h02);
		ccr_host_model_inst.pulse(1);
		rdChk(ccr_pkg::IDX_STATUS, 8'h03);
		ccr_host_model_inst.pulse(2);
		rdChk(ccr_pkg::IDX_STATUS, 8'h01);
		ccr_host_model_inst.setCode(3'h5);
		rdChk(ccr_pkg::IDX_STATUS, 8'h15);
		ccr_host_model_inst.setCode(3'h0);
		ccr_host_model_inst.setAlarm(1'h1);
		for (int s = 0; s < 4; s++) begin
			wr(ccr_pkg::IDX_PIN, {5'h00, s[1:0], 1'h0});
			tick(2);
			`CHK("statePin", !s[0], calibrationStatePin)
		end
		// Skipped foreground
		wr(ccr_pkg::IDX_CTRL, 8'h00);
		tick(3);
		`CHK("fgRun", 1'h0, engOut.fgRun)
		rdChk(ccr_pkg::IDX_STATUS, 8'h03);
		// Trigger sources
		ccr_host_model_inst.setPin(1'h1);
		wr(ccr_pkg::IDX_SOFT, 8'h00);
		tick(2);
		`CHK("trigger", 1'h0, engOut.trigger)
		wr(ccr_pkg::IDX_SOFT, 8'h01);
		tick(2);
		`CHK("trigger", 1'h1, engOut.trigger)
		wr(ccr_pkg::IDX_PIN, 8'h01);
		wr(ccr_pkg::IDX_SOFT, 8'h00);
		tick(5);
		`CHK("trigger", 1'h1, engOut.trigger)
		ccr_host_model_inst.setPin(1'h0);
		tick(5);
		`CHK("trigger", 1'h0, engOut.trigger)
		// Interrupt raise, clear, mask
		wr(ccr_pkg::IDX_IRQ_STS, 8'h0F);
		rdChk(ccr_pkg::IDX_IRQ_STS, 8'h00);
		wr(ccr_pkg::IDX_IRQ_MASK, 8'h01);
		wr(ccr_pkg::IDX_CTRL, 8'h01);
		ccr_host_model_inst.pulse(0);
		`CHK("irq", 1'h1, irq)
		wr(ccr_pkg::IDX_IRQ_STS, 8'h01);
		tick(2);
		`CHK("irq", 1'h0, irq)
		wr(ccr_pkg::IDX_IRQ_MASK, 8'h00);
		wr(ccr_pkg::IDX_CTRL, 8'h04);
		tick(1);
		`CHK("link", 1'h1, serialLinkEnable)
		results();
	end
endmodule : ccr_regs_bench
